//--- shared/uss_defines.svh
// Functional notes
// - Clocked-mode select high makes the port shift against a clock line.
// - Master select low makes the port a slave using the external clock.
// - Both receive enables low means transmit; either high means receive.
// - Serial port enable high activates the port; low keeps it inactive.
// - Slave transmit matches master transmit except during low-power sleep.
// - Two words loaded then sleep: first word moves to shifter at once.
// - Second word stays buffered and the buffer empty flag stays clear.
// - After first word shifts out, second loads and empty flag sets.
// - Flag with peripheral and transmit enables wakes device; global adds interrupt.
// - Nine-bit select set first; ninth bit shifts out last.
// - Writing the low eight bits to the buffer starts transmission, done last.
`ifndef USS_DEFINES_SVH
`define USS_DEFINES_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define USS_OFF_CTRL 8'h00
`define USS_OFF_TXBUF 8'h04
`define USS_OFF_STAT 8'h08
`define USS_OFF_IEN 8'h0C
`define USS_OFF_ICLR 8'h10
`define USS_OFF_INTC 8'h14

// ----------------------------------------
// Control register fields
// ----------------------------------------
`define USS_CTRL_SYNC 0
`define USS_CTRL_MSEL 1
`define USS_CTRL_SINGLE_RECEIVE_ENABLE 2
`define USS_CTRL_CONTINUOUS_RECEIVE_ENABLE 3
`define USS_CTRL_SERIAL_PORT_ENABLE 4
`define USS_CTRL_TRANSMIT_ENABLE 5
`define USS_CTRL_NINE 6
`define USS_CTRL_D9 7
`define USS_CTRL_SLEEP 8
`define USS_CTRL_W 9
`define USS_CTRL_RST 9'h000

// ----------------------------------------
// Status and interrupt fields
// ----------------------------------------
`define USS_ST_TXE 0
`define USS_ST_SHIFT_IDLE 1
`define USS_EV_W 2
`define USS_EV_DONE 0
`define USS_EV_LOAD 1
`define USS_INTC_PERIPHERAL_INTERRUPT_ENABLE 0
`define USS_INTC_GIE 1

// ----------------------------------------
// Bus responses and counts
// ----------------------------------------
`define USS_RESP_OKAY 2'h0
`define USS_RESP_SLVERR 2'h2
`define USS_BITS_8 4'h8
`define USS_BITS_9 4'h9

`endif

//--- shared/uss_pkg.sv
package uss_pkg;
  // Transmit shifter states
  typedef enum logic [2:0] {
    USS_IDLE = 3'b001,
    USS_SHIFT = 3'b010,
    USS_LAST = 3'b100
  } uss_state_t;
endpackage : uss_pkg

//--- logic/uss_sync.sv
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// Three-stage pin synchroniser with edge detect
// ----------------------------------------
module uss_sync (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Raw pin
  input wire logic pin_in,
  // Filtered level and edges
  output logic level,
  output logic rise,
  output logic fall
);
  logic s1_r;
  logic s2_r;
  logic s3_r;
  logic lvl_r;

  // Shift chain; first stage feeds only the second
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
    end else begin
      s1_r <= pin_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // Level moves only when stages two and three agree
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lvl_r <= 1'b0;
    end else if (s2_r == s3_r) begin
      lvl_r <= s3_r;
    end
  end

  // Edges are single-cycle pulses
  assign level = lvl_r;
  assign rise = (s2_r == s3_r) && s3_r && !lvl_r;
  assign fall = (s2_r == s3_r) && !s3_r && lvl_r;
endmodule : uss_sync
`default_nettype wire

//--- logic/uss_tx.sv
// Design decisions made here: the register offsets and register access over AXI4-Lite.
`timescale 1ns/10ps
`default_nettype none
`include "uss_defines.svh"
module uss_tx (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Shift clock pin (input in every mode; its output enable is never asserted)
  input wire logic shift_timing_pin_i,
  output logic shift_timing_pin_o,
  output logic shift_timing_pin_oe_n,
  // Data pin
  output logic data_pin_o,
  output logic data_pin_oe_n,
  // Interrupt and wake
  output logic irq,
  output logic wake
);
  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  logic [`USS_CTRL_W-1:0] ctrl_r;
  logic [7:0] buf_r;
  logic buf_d9_r;
  logic buf_full_r;
  logic [8:0] tsr_r;
  logic [3:0] bitcnt_r;
  logic [3:0] nbits_r;
  uss_pkg::uss_state_t state_r;
  logic [`USS_EV_W-1:0] ev_stat_r;
  logic [`USS_EV_W-1:0] ev_en_r;
  logic [1:0] intc_r;
  logic txe_flag_r;
  logic aw_got_r;
  logic w_got_r;
  logic [7:0] aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic ck_level;
  logic ck_rise;
  logic ck_fall;
  logic tx_active;
  logic wr_go;
  logic wr_txbuf;
  logic load_tsr;
  logic done_pulse;
  logic [`USS_EV_W-1:0] ev_set;
  logic [`USS_EV_W-1:0] ev_clr;

  // ----------------------------------------
  // Pin conditioning
  // ----------------------------------------
  // Link clock is sampled, not used as a clock
  uss_sync u_ck_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .pin_in(shift_timing_pin_i),
    .level(ck_level),
    .rise(ck_rise),
    .fall(ck_fall)
  );

  // Port live only in sync slave transmit with transmit enabled
  assign tx_active = ctrl_r[`USS_CTRL_SERIAL_PORT_ENABLE]
    && ctrl_r[`USS_CTRL_SYNC]
    && !ctrl_r[`USS_CTRL_MSEL]
    && !ctrl_r[`USS_CTRL_SINGLE_RECEIVE_ENABLE] && !ctrl_r[`USS_CTRL_CONTINUOUS_RECEIVE_ENABLE]
    && ctrl_r[`USS_CTRL_TRANSMIT_ENABLE];

  // ----------------------------------------
  // AXI4-Lite write path
  // ----------------------------------------
  assign wr_go = aw_got_r && w_got_r && !s_axi_bvalid;
  assign wr_txbuf = wr_go && (aw_addr_r == `USS_OFF_TXBUF) && w_strb_r[0];

  // Capture address and data in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      aw_addr_r <= 8'h00;
      w_data_r <= 32'h0000_0000;
      w_strb_r <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end else if (wr_go) begin
        aw_got_r <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end else if (wr_go) begin
        w_got_r <= 1'b0;
      end
    end
  end

  // Ready registered; high while slot is empty and no write response is pending
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_awready <= !aw_got_r && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
      s_axi_wready <= !w_got_r && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
    end
  end

  // Write response; unmapped offsets answer SLVERR
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `USS_RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= (aw_addr_r > `USS_OFF_INTC || aw_addr_r[1:0] != 2'h0) ?
        `USS_RESP_SLVERR : `USS_RESP_OKAY;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Configuration registers; low byte lane, except CTRL bit 8 taken from byte lane one
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r <= `USS_CTRL_RST;
      ev_en_r <= 2'h0;
      intc_r <= 2'h0;
    end else if (wr_go) begin
      if (aw_addr_r == `USS_OFF_CTRL) begin
        if (w_strb_r[0]) ctrl_r[7:0] <= w_data_r[7:0];
        if (w_strb_r[1]) ctrl_r[8] <= w_data_r[8];
      end
      if (aw_addr_r == `USS_OFF_IEN && w_strb_r[0]) ev_en_r <= w_data_r[1:0];
      if (aw_addr_r == `USS_OFF_INTC && w_strb_r[0]) intc_r <= w_data_r[1:0];
    end
  end

  // ----------------------------------------
  // Transmit buffer
  // ----------------------------------------
  // Buffer accepts a write only when empty; a write while full is dropped
  assign load_tsr = buf_full_r && tx_active && (state_r == uss_pkg::USS_IDLE);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      buf_r <= 8'h00;
      buf_d9_r <= 1'b0;
      buf_full_r <= 1'b0;
    end else if (!ctrl_r[`USS_CTRL_SERIAL_PORT_ENABLE]) begin
      buf_full_r <= 1'b0;
    end else if (wr_txbuf && !buf_full_r) begin
      buf_r <= w_data_r[7:0];
      buf_d9_r <= ctrl_r[`USS_CTRL_D9];
      buf_full_r <= 1'b1;
    end else if (load_tsr) begin
      buf_full_r <= 1'b0;
    end
  end

  // Empty flag: in sleep it holds clear until a word moves on a completed shift
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      txe_flag_r <= 1'b1;
    end else if (wr_txbuf && !buf_full_r && ctrl_r[`USS_CTRL_SERIAL_PORT_ENABLE]) begin
      txe_flag_r <= 1'b0;
    end else if (!buf_full_r || load_tsr) begin
      if (!ctrl_r[`USS_CTRL_SLEEP] || state_r == uss_pkg::USS_IDLE) begin
        txe_flag_r <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Shift engine, LSB first on master edges
  // ----------------------------------------
  // Data changes a few cycles after the master falling edge; master samples just before each falling edge
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r <= uss_pkg::USS_IDLE;
      tsr_r <= 9'h000;
      bitcnt_r <= 4'h0;
      nbits_r <= `USS_BITS_8;
      data_pin_o <= 1'b1;
    end else if (!tx_active) begin
      state_r <= uss_pkg::USS_IDLE;
      data_pin_o <= 1'b1;
    end else begin
      unique case (state_r)
        uss_pkg::USS_IDLE: begin
          if (load_tsr) begin
            tsr_r <= {buf_d9_r, buf_r};
            nbits_r <= ctrl_r[`USS_CTRL_NINE] ? `USS_BITS_9 : `USS_BITS_8;
            data_pin_o <= buf_r[0];
            bitcnt_r <= 4'h1;
            state_r <= uss_pkg::USS_SHIFT;
          end
        end
        uss_pkg::USS_SHIFT: begin
          if (ck_fall) begin
            if (bitcnt_r == nbits_r) begin
              state_r <= uss_pkg::USS_LAST;
            end else begin
              data_pin_o <= tsr_r[bitcnt_r];
              bitcnt_r <= bitcnt_r + 4'h1;
            end
          end
        end
        uss_pkg::USS_LAST: begin
          state_r <= uss_pkg::USS_IDLE;
        end
        default: state_r <= uss_pkg::USS_IDLE;
      endcase
    end
  end

  assign done_pulse = (state_r == uss_pkg::USS_LAST);

  // Never drive the clock pin in slave mode
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      shift_timing_pin_o <= 1'b0;
      shift_timing_pin_oe_n <= 1'b1;
      data_pin_oe_n <= 1'b1;
    end else begin
      shift_timing_pin_o <= 1'b0;
      shift_timing_pin_oe_n <= 1'b1;
      data_pin_oe_n <= !tx_active;
    end
  end

  // ----------------------------------------
  // Events, interrupt and wake
  // ----------------------------------------
  assign ev_set = {load_tsr, done_pulse};
  assign ev_clr = (wr_go && aw_addr_r == `USS_OFF_ICLR && w_strb_r[0]) ?
    w_data_r[1:0] : 2'h0;

  // Set beats clear in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ev_stat_r <= 2'h0;
    end else begin
      ev_stat_r <= (ev_stat_r & ~ev_clr) | ev_set;
    end
  end

  // Wake needs peripheral and transmit enables in sleep; irq needs global, with those enables or an enabled event
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wake <= 1'b0;
      irq <= 1'b0;
    end else begin
      wake <= txe_flag_r && ev_en_r[`USS_EV_LOAD] && intc_r[`USS_INTC_PERIPHERAL_INTERRUPT_ENABLE]
        && ctrl_r[`USS_CTRL_SLEEP];
      irq <= ((txe_flag_r && ev_en_r[`USS_EV_LOAD] && intc_r[`USS_INTC_PERIPHERAL_INTERRUPT_ENABLE])
        || |(ev_stat_r & ev_en_r)) && intc_r[`USS_INTC_GIE];
    end
  end

  // ----------------------------------------
  // AXI4-Lite read path
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `USS_RESP_OKAY;
    end else if (s_axi_rvalid) begin
      if (s_axi_rready) s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= `USS_RESP_OKAY;
      unique case (s_axi_araddr)
        `USS_OFF_CTRL: s_axi_rdata <= {23'h0, ctrl_r};
        `USS_OFF_STAT: s_axi_rdata <= {28'h0, ck_level, buf_full_r,
          state_r == uss_pkg::USS_IDLE, txe_flag_r};
        `USS_OFF_IEN: s_axi_rdata <= {30'h0, ev_en_r};
        `USS_OFF_INTC: s_axi_rdata <= {30'h0, intc_r};
        `USS_OFF_TXBUF, `USS_OFF_ICLR: s_axi_rdata <= 32'h0000_0000;
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= `USS_RESP_SLVERR;
        end
      endcase
    end else begin
      s_axi_arready <= 1'b1;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  sequence seq_load;
    load_tsr;
  endsequence

  AST_CLK_NEVER_DRIVEN: assert property (@(posedge aclk) disable iff (!aresetn)
    shift_timing_pin_oe_n) else $error("clock pin driven in slave mode");
  AST_INACTIVE_IDLE: assert property (@(posedge aclk) disable iff (!aresetn)
    !ctrl_r[`USS_CTRL_SERIAL_PORT_ENABLE] |=> state_r == uss_pkg::USS_IDLE)
    else $error("shifter busy while port disabled");
  AST_MASTER_NO_SHIFT: assert property (@(posedge aclk) disable iff (!aresetn)
    ctrl_r[`USS_CTRL_MSEL] |-> !load_tsr) else $error("shift started in master mode");
  AST_RX_NO_SHIFT: assert property (@(posedge aclk) disable iff (!aresetn)
    (ctrl_r[`USS_CTRL_SINGLE_RECEIVE_ENABLE] || ctrl_r[`USS_CTRL_CONTINUOUS_RECEIVE_ENABLE]) |-> !load_tsr)
    else $error("transmit started in receive mode");
  AST_ASYNC_NO_SHIFT: assert property (@(posedge aclk) disable iff (!aresetn)
    !ctrl_r[`USS_CTRL_SYNC] |-> !load_tsr) else $error("shift started in async mode");
  AST_LOAD_STARTS: assert property (@(posedge aclk) disable iff (!aresetn)
    seq_load |=> state_r == uss_pkg::USS_SHIFT && !buf_full_r)
    else $error("load did not start shifting");
  AST_SLEEP_FLAG_HOLD: assert property (@(posedge aclk) disable iff (!aresetn)
    (ctrl_r[`USS_CTRL_SLEEP] && buf_full_r && state_r == uss_pkg::USS_SHIFT && $stable(ctrl_r))
    |=> !txe_flag_r) else $error("empty flag set while word waits in sleep");
  AST_FLAG_AFTER_LOAD: assert property (@(posedge aclk) disable iff (!aresetn)
    seq_load ##1 !(wr_txbuf) |=> txe_flag_r) else $error("flag not set after buffer load");
  AST_LSB_FIRST: assert property (@(posedge aclk) disable iff (!aresetn)
    seq_load |=> data_pin_o == $past(buf_r[0])) else $error("first bit not LSB");
  AST_WAKE: assert property (@(posedge aclk) disable iff (!aresetn)
    (txe_flag_r && ev_en_r[`USS_EV_LOAD] && intc_r[`USS_INTC_PERIPHERAL_INTERRUPT_ENABLE] && ctrl_r[`USS_CTRL_SLEEP])
    |=> wake) else $error("wake missing");
endmodule : uss_tx
`default_nettype wire

//--- tb/uss_master_model.sv
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// External master driving the shift clock
// ----------------------------------------
module uss_master_model (
  // Device data pin
  input wire logic data_pin_o,
  input wire logic data_pin_oe_n,
  // Shift clock to the device
  output logic shift_clk
);
  // Clock rests low between frames, never free-running
  initial shift_clk = 1'b0;
  // One frame, LSB first; bit taken just before each falling edge,
  // the point furthest from the device's late data update
  task automatic frame(input int nbits, output logic [8:0] word);
    word = 9'h000;
    #137;
    for (int i = 0; i < nbits; i++) begin
      shift_clk = 1'b1;
      #399;
      word[i] = data_pin_oe_n ? 1'bx : data_pin_o;
      #1;
      shift_clk = 1'b0;
      #400;
    end
  endtask : frame
endmodule : uss_master_model
`default_nettype wire

//--- tb/tb_uss_tx.sv
`timescale 1ns/10ps
`default_nettype none
`include "uss_defines.svh"
module tb_uss_tx;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic awvalid = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic [7:0] araddr = 8'h00;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, irq, wake, sclk;
  logic shift_timing_pin_oe_n, data_pin_o, data_pin_oe_n;
  logic [1:0] bresp, rresp, resp;
  logic [31:0] rdata, rd_data;
  logic [8:0] word;
  int mismatches = 0;
  int cmp_count = 0;
  int cycles = 0;
  typedef struct {logic [8:0] ctrl; logic [7:0] data; int nbits; logic [8:0] exp; logic live;} uss_row_t;
  // Ordinary cases; disabled rows last, since their word may stay buffered
  uss_row_t rows [6] = '{
    '{9'h031, 8'hA5, 8, 9'h0A5, 1'b1},
    '{9'h071, 8'h3C, 9, 9'h03C, 1'b1},
    '{9'h0F1, 8'h00, 9, 9'h100, 1'b1},
    '{9'h031, 8'h80, 8, 9'h080, 1'b1},
    '{9'h035, 8'h55, 8, 9'h000, 1'b0},
    '{9'h021, 8'h55, 8, 9'h000, 1'b0}};

  // ----------------------------------------
  // Clock, timeout, instances
  // ----------------------------------------
  always #50 aclk = ~aclk;
  // Ceiling far above the expected run of under a thousand cycles
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches++;
      finish_test();
    end
  end
  uss_tx i_uss_tx (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .shift_timing_pin_i(sclk), .shift_timing_pin_o(),
    .shift_timing_pin_oe_n(shift_timing_pin_oe_n), .data_pin_o(data_pin_o),
    .data_pin_oe_n(data_pin_oe_n), .irq(irq), .wake(wake));
  uss_master_model i_uss_master_model (.data_pin_o(data_pin_o),
    .data_pin_oe_n(data_pin_oe_n), .shift_clk(sclk));

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic finish_test();
    if (mismatches == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : finish_test
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  // Address and data offered together, each dropped once taken
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wstrb <= 4'hF;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask : axi_wr
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : axi_rd
  // Poll a status bit until set; only the timeout ends a hang
  task automatic wait_stat(input int b);
    do axi_rd(`USS_OFF_STAT, rd_data, resp);
    while (rd_data[b] !== 1'b1);
  endtask : wait_stat
  task automatic do_reset(input int n);
    aresetn <= 1'b0;
    repeat (n) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
  endtask : do_reset

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    do_reset(12);
    for (int k = 0; k < 6; k++) begin
      axi_wr(`USS_OFF_CTRL, {23'h0, rows[k].ctrl}, resp);
      axi_wr(`USS_OFF_TXBUF, {24'h0, rows[k].data}, resp);
      chk("txbuf_bresp", {30'h0, `USS_RESP_OKAY}, {30'h0, resp});
      i_uss_master_model.frame(rows[k].nbits, word);
      if (rows[k].live) begin
        chk("word", {23'h0, rows[k].exp}, {23'h0, word});
        wait_stat(`USS_ST_SHIFT_IDLE);
        chk("stat_empty", 32'h1, {31'h0, rd_data[`USS_ST_TXE]});
      end else begin
        chk("data_oe_n", 32'h1, {31'h0, data_pin_oe_n});
      end
      chk("clk_oe_n", 32'h1, {31'h0, shift_timing_pin_oe_n});
    end
    // Mid-run reset clears everything; the port-disabled last row has already emptied the buffer
    do_reset(3);
    chk("rst_pins", 32'h3, {28'h0, irq, wake, data_pin_o, data_pin_oe_n});
    axi_rd(`USS_OFF_CTRL, rd_data, resp);
    chk("rst_ctrl", 32'h0, rd_data);
    axi_rd(`USS_OFF_STAT, rd_data, resp);
    chk("rst_stat", 32'h3, rd_data & 32'h7);
    axi_rd(8'h40, rd_data, resp);
    chk("unmapped", {30'h0, `USS_RESP_SLVERR}, {30'h0, resp});
    // Two words queued, then sleep
    axi_wr(`USS_OFF_CTRL, 32'h31, resp);
    axi_wr(`USS_OFF_IEN, 32'h2, resp);
    axi_wr(`USS_OFF_INTC, 32'h1, resp);
    axi_wr(`USS_OFF_TXBUF, 32'h5A, resp);
    axi_wr(`USS_OFF_TXBUF, 32'h96, resp);
    axi_wr(`USS_OFF_CTRL, 32'h131, resp);
    axi_rd(`USS_OFF_STAT, rd_data, resp);
    chk("sleep_empty", 32'h0, {31'h0, rd_data[`USS_ST_TXE]});
    chk("sleep_wake", 32'h0, {31'h0, wake});
    i_uss_master_model.frame(8, word);
    chk("first_word", 32'h5A, {23'h0, word});
    wait_stat(`USS_ST_TXE);
    chk("wake_irq", 32'h2, {30'h0, wake, irq});
    axi_wr(`USS_OFF_INTC, 32'h3, resp);
    repeat (2) @(posedge aclk);
    chk("irq_gie", 32'h1, {31'h0, irq});
    i_uss_master_model.frame(8, word);
    chk("second_word", 32'h96, {23'h0, word});
    // Mask, clear, then only the done event enabled
    axi_wr(`USS_OFF_IEN, 32'h0, resp);
    repeat (2) @(posedge aclk);
    chk("irq_masked", 32'h0, {31'h0, irq});
    axi_wr(`USS_OFF_ICLR, 32'h3, resp);
    axi_wr(`USS_OFF_IEN, 32'h1, resp);
    repeat (2) @(posedge aclk);
    chk("irq_cleared", 32'h0, {31'h0, irq});
    finish_test();
  end
endmodule : tb_uss_tx
`default_nettype wire
